// ### design/asm_ctrl.sv
`timescale 1ns/10ps
module asm_ctrl import asm_pkg::*; #(
  parameter int SAMPLE_W = 16,
  parameter int MUTE_STEPS = ASM_MUTE_STEPS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fs_tick,
  input wire logic [SAMPLE_W-1:0] play_in,
  output logic [SAMPLE_W-1:0] play_out,
  input wire logic [7:0] alc_gain_in,
  input wire logic rec_zero_cross,
  input wire logic play_zero_cross,
  output logic rec_auto,
  output logic play_auto,
  output logic beep_in_on,
  output logic beep_spk_route,
  output logic beep_line_route,
  output logic line_dac_on,
  output logic [1:0] line_state
);
  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ctrl;
  logic [15:0] alc_cfg;
  logic [7:0] gain_live;
  logic [7:0] mute_att;
  logic [SAMPLE_W-1:0] play_q;
  logic [10:0] rec_cnt, play_cnt;
  asm_alc_state_t rec_st, play_st;
  logic wr, rd;
  logic soft_mute_ctl, beep_power, beep_to_speaker, beep_to_line, dac_to_line;
  logic line_out_power, line_out_save, filter_power, alc_rec_en, alc_play_en;
  logic [1:0] zero_cross_timeout_sel;
  logic [10:0] zt_period;
  logic [SAMPLE_W+8:0] prod;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign pready = 1'b1;
  assign soft_mute_ctl = ctrl[0];
  assign beep_power = ctrl[1];
  assign beep_to_speaker = ctrl[2];
  assign beep_to_line = ctrl[3];
  assign dac_to_line = ctrl[4];
  assign line_out_power = ctrl[5];
  assign line_out_save = ctrl[6];
  assign filter_power = ctrl[7];
  assign alc_rec_en = alc_cfg[0] && filter_power;
  assign alc_play_en = alc_cfg[1] && filter_power;
  // alc_cfg[15:4] holds the frozen limiter and recovery settings for the host; alc_cfg[3:2] selects the hand-over timeout
  assign zero_cross_timeout_sel = alc_cfg[3:2];
  assign zt_period = 11'(ASM_ZT_BASE) << zero_cross_timeout_sel;

  ////////////////////////////////////////////////////////////////////////
  // APB slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 8'h00;
      alc_cfg <= 16'h0000;
    end else if (wr) begin
      if (paddr == ASM_CTRL_OFS) begin
        ctrl <= pwdata[7:0];
      end else if (paddr == ASM_ALC_OFS) begin
        alc_cfg <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        if (paddr == ASM_CTRL_OFS) begin
          prdata <= {24'h00_0000, ctrl};
        end else if (paddr == ASM_ALC_OFS) begin
          prdata <= {16'h0000, alc_cfg};
        end else if (paddr == ASM_GAIN_OFS) begin
          prdata <= {24'h00_0000, gain_live};
        end else if (paddr == ASM_STAT_OFS) begin
          prdata <= {16'h0000, mute_att, 4'h0, line_state, play_auto, rec_auto};
        end else if (rd) begin
          pslverr <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Live gain capture, code FFH means mute, 0EH top
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_live <= ASM_GAIN_RST;
    end else if (alc_gain_in == ASM_GAIN_MUTE || alc_gain_in >= ASM_GAIN_MAX) begin
      gain_live <= alc_gain_in;
    end else begin
      gain_live <= ASM_GAIN_MAX;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Level control hand-over, recording path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_st <= ASM_MANUAL;
      rec_cnt <= 11'h000;
    end else begin
      case (rec_st)
        ASM_MANUAL: if (alc_rec_en) rec_st <= ASM_AUTO;
        ASM_AUTO: begin
          rec_cnt <= 11'h000;
          if (!alc_rec_en) rec_st <= ASM_HANDOFF;
        end
        ASM_HANDOFF: begin
          if (alc_rec_en) begin
            rec_st <= ASM_AUTO;
          end else if (fs_tick) begin
            rec_cnt <= rec_cnt + 11'h001;
            if (rec_cnt + 11'h001 >= zt_period) rec_st <= ASM_MANUAL;
          end
        end
        default: rec_st <= ASM_MANUAL;
      endcase
    end
  end

  // Playback path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      play_st <= ASM_MANUAL;
      play_cnt <= 11'h000;
    end else begin
      case (play_st)
        ASM_MANUAL: if (alc_play_en) play_st <= ASM_AUTO;
        ASM_AUTO: begin
          play_cnt <= 11'h000;
          if (!alc_play_en) play_st <= ASM_HANDOFF;
        end
        ASM_HANDOFF: begin
          if (alc_play_en) begin
            play_st <= ASM_AUTO;
          end else if (fs_tick) begin
            play_cnt <= play_cnt + 11'h001;
            if (play_cnt + 11'h001 >= zt_period) play_st <= ASM_MANUAL;
          end
        end
        default: play_st <= ASM_MANUAL;
      endcase
    end
  end

  assign rec_auto = (rec_st != ASM_MANUAL);
  assign play_auto = (play_st != ASM_MANUAL);

  ////////////////////////////////////////////////////////////////////////
  // Soft mute ramp, mute_att counts 0 (0 dB) to MUTE_STEPS (silence)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_att <= 8'h00;
    end else if (fs_tick) begin
      if (soft_mute_ctl && mute_att < 8'(MUTE_STEPS)) begin
        mute_att <= mute_att + 8'h01;
      end else if (!soft_mute_ctl && mute_att != 8'h00) begin
        mute_att <= mute_att - 8'h01;
      end
    end
  end

  assign prod = $signed(play_in) * $signed({1'b0, 8'(MUTE_STEPS) - mute_att});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      play_q <= '0;
    end else if (fs_tick) begin
      if (mute_att == 8'h00) begin
        play_q <= play_in;
      end else begin
        play_q <= SAMPLE_W'($signed(prod) / $signed(25'(MUTE_STEPS)));
      end
    end
  end
  assign play_out = play_q;

  ////////////////////////////////////////////////////////////////////////
  // Beep and line output controls
  assign beep_in_on = beep_power;
  assign beep_spk_route = beep_power && beep_to_speaker;
  assign beep_line_route = beep_power && beep_to_line;
  assign line_dac_on = dac_to_line;

  always_comb begin
    if (line_out_save) begin
      line_state = ASM_LINE_SAVE;
    end else if (line_out_power) begin
      line_state = ASM_LINE_UP;
    end else begin
      line_state = ASM_LINE_DOWN;
    end
  end
endmodule : asm_ctrl

// ### shared/asm_pkg.sv
// Operation
// - Live level control gain code is readable by the host.
// - Gain code 0EH is +36 dB, 0.375 dB lower per code, FFH mutes.
// - Disabling a path hands over to manual gain after the timeout period.
// - Soft mute acts on digital playback samples before conversion.
// - Mute ramps attenuation up to silence over 245 sample periods.
// - Unmute ramps attenuation back to 0 dB over 245 sample periods.
// - Early unmute reverses the ramp and returns to 0 dB within that window.
// - Beep power enables beep input; two bits route it to speaker, line.
// - Converter feed to the line output is off when dac_to_line is 0.
// - Line output is powered down with both bits 0, power-save when save is 1.
// - Line power 1 with save 0 makes the line output active.
package asm_pkg;
  localparam logic [31:0] ASM_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] ASM_ALC_OFS = 32'h0000_0004;
  localparam logic [31:0] ASM_GAIN_OFS = 32'h0000_0008;
  localparam logic [31:0] ASM_STAT_OFS = 32'h0000_000C;
  localparam logic [31:0] ASM_GAIN_SET_OFS = 32'h0000_0010;
  localparam int ASM_MUTE_STEPS = 245;
  localparam int ASM_ZT_BASE = 128;
  localparam logic [7:0] ASM_GAIN_RST = 8'h6E;
  localparam logic [7:0] ASM_GAIN_MAX = 8'h0E;
  localparam logic [7:0] ASM_GAIN_MUTE = 8'hFF;
  localparam logic [1:0] ASM_LINE_DOWN = 2'h0;
  localparam logic [1:0] ASM_LINE_SAVE = 2'h1;
  localparam logic [1:0] ASM_LINE_UP = 2'h2;
  typedef enum logic [2:0] {
    ASM_MANUAL = 3'b001,
    ASM_AUTO = 3'b010,
    ASM_HANDOFF = 3'b100
  } asm_alc_state_t;
endpackage : asm_pkg

// ### verif/asm_ctrl_assertions.sv
`timescale 1ns/10ps
module asm_ctrl_assertions import asm_pkg::*; #(
  parameter int SAMPLE_W = 16,
  parameter int MUTE_STEPS = ASM_MUTE_STEPS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic fs_tick,
  input wire logic [SAMPLE_W-1:0] play_in,
  input wire logic [SAMPLE_W-1:0] play_out,
  input wire logic [7:0] alc_gain_in,
  input wire logic rec_auto,
  input wire logic beep_in_on,
  input wire logic line_dac_on,
  input wire logic [1:0] line_state
);
  logic mute;
  logic [8:0] mcnt;
  logic [11:0] zcnt;
  logic [1:0] zsel;
  wire wr = psel && penable && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wr_ctrl; wr && paddr == ASM_CTRL_OFS; endsequence
  sequence rd_gain; psel && !penable && !pwrite && paddr == ASM_GAIN_OFS; endsequence
  ////////////////////////////////////////
  // Ticks since the mute bit last changed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute <= 1'b0;
      mcnt <= 9'h1FF;
    end else if (wr && paddr == ASM_CTRL_OFS && pwdata[0] != mute) begin
      mute <= pwdata[0];
      mcnt <= 9'h0;
    end else if (fs_tick && mcnt != 9'h1FF) begin
      mcnt <= mcnt + 9'h1;
    end
  end
  // Ticks since the last level control write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zcnt <= 12'h0;
      zsel <= 2'h0;
    end else if (wr && paddr == ASM_ALC_OFS) begin
      zcnt <= 12'h0;
      zsel <= pwdata[3:2];
    end else if (fs_tick && zcnt != 12'hFFF) begin
      zcnt <= zcnt + 12'h1;
    end
  end
  ////////////////////////////////////////
  AST_GAIN_LIVE: assert property (rd_gain ##0 ($stable(alc_gain_in) &&
    alc_gain_in >= ASM_GAIN_MAX) |=> prdata[7:0] == $past(alc_gain_in)) else $error("gain read");
  AST_GAIN_CLAMP: assert property (rd_gain ##0 ($stable(alc_gain_in) &&
    alc_gain_in < ASM_GAIN_MAX) |=> prdata[7:0] == ASM_GAIN_MAX) else $error("gain clamp");
  AST_BEEP: assert property (wr_ctrl |=> beep_in_on == $past(pwdata[1]))
    else $error("beep power");
  AST_DAC: assert property (wr_ctrl ##0 !pwdata[4] |=> !line_dac_on)
    else $error("dac feed");
  AST_LINE: assert property (wr_ctrl |=> line_state == ($past(pwdata[6]) ? ASM_LINE_SAVE :
    $past(pwdata[5]) ? ASM_LINE_UP : ASM_LINE_DOWN)) else $error("line state");
  AST_MUTE: assert property (mute && mcnt > MUTE_STEPS + 1 |-> play_out == '0)
    else $error("mute not silent");
  AST_UNMUTE: assert property (!mute && mcnt > MUTE_STEPS + 1 && fs_tick
    |=> play_out == $past(play_in)) else $error("unmute level");
  AST_HANDOFF: assert property ($fell(rec_auto) |-> zcnt + 2 >= (ASM_ZT_BASE << zsel) &&
    zcnt <= (ASM_ZT_BASE << zsel) + 1) else $error("handover time");
endmodule : asm_ctrl_assertions
bind asm_ctrl asm_ctrl_assertions #(.SAMPLE_W(SAMPLE_W), .MUTE_STEPS(MUTE_STEPS)) u_chk (.*);

// ### verif/asm_host.sv
`timescale 1ns/10ps
module asm_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata
);
  logic [31:0] rdat;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // One transfer, held until pready
  task xfer(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : asm_host

// ### verif/asm_ctrl_tb.sv
`timescale 1ns/10ps
module asm_ctrl_tb import asm_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, fs_tick = 1'b0;
  logic rec_zero_cross = 1'b0, play_zero_cross = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, rec_auto, play_auto;
  logic beep_in_on, beep_spk_route, beep_line_route, line_dac_on;
  logic [31:0] paddr, pwdata, prdata;
  logic [15:0] play_in = 16'h1000, play_out;
  logic [7:0] alc_gain_in = 8'h6E;
  logic [1:0] line_state;
  logic [2:0] fc = 3'h0;
  int num_errors = 0, n_checks = 0, cyc = 0;
  logic [15:0] gv [4] = '{16'h3030, 16'h050E, 16'hFFFF, 16'hFEFE};
  logic [15:0] cv [6] = '{16'h5E3D, 16'h7C05, 16'h2222, 16'h6001, 16'h4001, 16'h0000};
  asm_ctrl dut (.*);
  asm_host host (.*);
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) begin
    fc <= fc + 3'h1;
    fs_tick <= (fc == 3'h7);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      conclude;
    end
  end
  ////////////////////////////////////////
  task chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task rd(input logic [31:0] a, e);
    host.xfer(1'b0, a, 32'h0);
    chk(host.rdat, e);
  endtask : rd
  task conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(ASM_GAIN_OFS, 32'h6E);
    for (int i = 0; i < 4; i++) begin
      alc_gain_in <= gv[i][15:8];
      rd(ASM_GAIN_OFS, {24'h0, gv[i][7:0]});
    end
    rd(32'h40, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      host.xfer(1'b1, ASM_CTRL_OFS, {24'h0, cv[i][15:8]});
      @(negedge pclk);
      chk({26'h0, beep_in_on, beep_spk_route, beep_line_route, line_dac_on, line_state},
        {24'h0, cv[i][7:0]});
    end
    @(posedge pclk iff fs_tick);
    host.xfer(1'b1, ASM_CTRL_OFS, 32'h1);
    repeat (250) @(posedge pclk iff fs_tick);
    rd(ASM_STAT_OFS, 32'hF500);
    chk({16'h0, play_out}, 32'h0);
    host.xfer(1'b1, ASM_CTRL_OFS, 32'h0);
    repeat (250) @(posedge pclk iff fs_tick);
    chk({16'h0, play_out}, 32'h1000);
    @(posedge pclk iff fs_tick);
    host.xfer(1'b1, ASM_CTRL_OFS, 32'h1);
    repeat (100) @(posedge pclk iff fs_tick);
    rd(ASM_STAT_OFS, 32'h6400);
    host.xfer(1'b1, ASM_CTRL_OFS, 32'h0);
    repeat (250) @(posedge pclk iff fs_tick);
    chk({16'h0, play_out}, 32'h1000);
    host.xfer(1'b1, ASM_CTRL_OFS, 32'h80);
    host.xfer(1'b1, ASM_ALC_OFS, 32'h3);
    rd(ASM_STAT_OFS, 32'h3);
    host.xfer(1'b1, ASM_ALC_OFS, 32'h0);
    repeat (120) @(posedge pclk iff fs_tick);
    rd(ASM_STAT_OFS, 32'h3);
    repeat (12) @(posedge pclk iff fs_tick);
    rd(ASM_STAT_OFS, 32'h0);
    conclude;
  end
endmodule : asm_ctrl_tb
